// ### shared/sfc_pkg.sv
// Constants and types for the serial frame checksum checker
package sfc_pkg;

  // Checksum generator x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Frame lengths in serial clocks
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] CMD_BITS   = 6'h18;
  localparam logic [5:0] CNT_MAX    = 6'h3F;

  // Payload lengths for the input and output checksums
  localparam int unsigned RD_BITS   = 8;
  localparam int unsigned CONV_BITS = 16;
  localparam int unsigned IN_BITS   = 24;

  // Command opcodes
  localparam logic [7:0] OP_RD  = 8'h10;
  localparam logic [7:0] OP_WR  = 8'h08;
  localparam logic [7:0] OP_SET = 8'h18;
  localparam logic [7:0] OP_CLR = 8'h20;

  // Register addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_GEN    = 8'h01;
  localparam logic [7:0] A_PROT   = 8'h02;
  localparam logic [7:0] A_GPIO   = 8'h03;
  localparam logic [7:0] A_PIN    = 8'h05;

  // Field positions
  localparam int unsigned STAT_ERR_BIT = 0;
  localparam int unsigned GEN_CRC_BIT  = 6;
  localparam int unsigned PROT_ALERT   = 0;
  localparam int unsigned PROT_SAFE    = 1;
  localparam int unsigned PROT_STOP    = 2;
  localparam int unsigned PROT_APP_LO  = 4;

  // Appended field codes
  localparam logic [1:0] APPEND_STATUS = 2'h2;
  localparam logic [1:0] STAT_HI       = 2'h2;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } sfc_pins_t;

  localparam sfc_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] addr;
    logic [7:0] data;
  } sfc_cmd_t;

  typedef enum logic {
    LNK_IDLE  = 1'b0,
    LNK_FRAME = 1'b1
  } sfc_lnk_t;

endpackage

// ### rtl/sfc_checker.sv
// Serial command frame checker with checksum, error flag and safe-state control
`timescale 1ns/1ps

module sfc_checker
  import sfc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Serial link pins
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  // Converter side
  input  wire logic [11:0] conv_data,
  input  wire logic       event_alert,
  output logic            alert,
  output logic            conv_abort,
  output logic      [7:0] pin_cfg_eff,
  output logic      [7:0] gpio_cfg_eff,
  output logic            cmd_valid,
  output sfc_cmd_t        cmd
);

  function automatic logic [7:0] crc8(input logic [23:0] d, input int unsigned n);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 24; i++) begin
      if (i < n) begin
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[23-i]) ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

  function automatic logic wr_ok(input logic [7:0] a, input logic flag);
    return !flag || a == A_STATUS || a == A_GEN;
  endfunction

  sfc_pins_t   s1_r, s2_r, s3_r, filt_r, prev_r;
  sfc_lnk_t    lnk_r;
  logic [31:0] rx_r, tx_r;
  logic [5:0]  cnt_r;
  logic        sdo_r;
  logic [7:0]  gen_r, prot_r, pin_r, gpio_r;
  logic        flag_r, rd_pend_r, alert_r, abort_r, cmd_valid_r;
  logic [7:0]  rd_data_r, rdata_r, pin_eff_r, gpio_eff_r;
  sfc_cmd_t    cmd_r;

  logic        cs_fall, cs_rise, sck_rise, sck_fall;
  logic        crc_en, frame_done, frame_err, frame_ok;
  sfc_cmd_t    pl;
  logic        is_wr, spi_wr, sw_wr, wr_en, flag_set, flag_clr;
  logic [7:0]  wr_addr, wr_data, cur, app;
  logic [15:0] d16;

  // Three-stage pin synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r <= PINS_IDLE;
      s2_r <= PINS_IDLE;
      s3_r <= PINS_IDLE;
    end else begin
      s1_r <= {spi_cs_n, spi_sclk, spi_sdi};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a level once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filt_r <= PINS_IDLE;
      prev_r <= PINS_IDLE;
    end else begin
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      prev_r <= filt_r;
    end
  end

  assign cs_fall  = prev_r.cs_n && !filt_r.cs_n;
  assign cs_rise  = !prev_r.cs_n && filt_r.cs_n;
  assign sck_rise = lnk_r == LNK_FRAME && !prev_r.sclk && filt_r.sclk;
  assign sck_fall = lnk_r == LNK_FRAME && prev_r.sclk && !filt_r.sclk;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lnk_r <= LNK_IDLE;
    end else begin
      case (lnk_r)
        LNK_IDLE:  if (cs_fall) lnk_r <= LNK_FRAME;
        LNK_FRAME: if (cs_rise) lnk_r <= LNK_IDLE;
        default:   lnk_r <= LNK_IDLE;
      endcase
    end
  end

  // Receive shifter and clock counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_r  <= '0;
      cnt_r <= '0;
    end else if (cs_fall) begin
      rx_r  <= '0;
      cnt_r <= '0;
    end else if (sck_rise) begin
      rx_r  <= {rx_r[30:0], filt_r.sdi};
      if (cnt_r != CNT_MAX) begin
        cnt_r <= 6'(cnt_r + 6'h01);
      end
    end
  end

  assign crc_en     = gen_r[GEN_CRC_BIT];
  assign frame_done = lnk_r == LNK_FRAME && cs_rise;
  assign pl         = crc_en ? rx_r[31:8] : rx_r[23:0];
  assign frame_err  = crc_en && (cnt_r != FRAME_BITS ||
                      crc8(rx_r[31:8], IN_BITS) != rx_r[7:0]);
  assign frame_ok   = frame_done && !frame_err && (crc_en || cnt_r >= CMD_BITS);

  always_comb begin
    case (pl.addr)
      A_STATUS: cur = {7'h00, flag_r};
      A_GEN:    cur = gen_r;
      A_PROT:   cur = prot_r;
      A_GPIO:   cur = gpio_r;
      A_PIN:    cur = pin_r;
      default:  cur = 8'h00;
    endcase
  end

  // Write decode; serial command wins over register port
  assign is_wr  = pl.opcode == OP_WR || pl.opcode == OP_SET || pl.opcode == OP_CLR;
  assign spi_wr = frame_ok && is_wr && wr_ok(pl.addr, flag_r);
  assign sw_wr  = reg_we && wr_ok(reg_addr, flag_r);
  assign wr_en  = spi_wr || sw_wr;

  always_comb begin
    wr_addr = spi_wr ? pl.addr : reg_addr;
    wr_data = reg_wdata;
    if (spi_wr) begin
      case (pl.opcode)
        OP_SET:  wr_data = cur | pl.data;
        OP_CLR:  wr_data = cur & ~pl.data;
        default: wr_data = pl.data;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gen_r  <= REG_RST;
      prot_r <= REG_RST;
      pin_r  <= REG_RST;
      gpio_r <= REG_RST;
    end else if (wr_en) begin
      if (wr_addr == A_GEN)  gen_r  <= wr_data;
      if (wr_addr == A_PROT) prot_r <= wr_data;
      if (wr_addr == A_PIN)  pin_r  <= wr_data;
      if (wr_addr == A_GPIO) gpio_r <= wr_data;
    end
  end

  // sticky flag, set wins over clear
  assign flag_set = frame_done && frame_err;
  assign flag_clr = wr_en && wr_addr == A_STATUS && wr_data[STAT_ERR_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_pend_r <= 1'b0;
      rd_data_r <= REG_RST;
    end else if (frame_ok && pl.opcode == OP_RD) begin
      rd_pend_r <= 1'b1;
      rd_data_r <= cur;
    end else if (cs_fall) begin
      rd_pend_r <= 1'b0;
    end
  end

  // Accepted commands handed on to the core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_valid_r <= 1'b0;
      cmd_r       <= '0;
    end else begin
      cmd_valid_r <= frame_ok;
      if (frame_ok) cmd_r <= pl;
    end
  end

  assign app = prot_r[PROT_APP_LO +: 2] == APPEND_STATUS ?
               {4'h0, STAT_HI, flag_r, event_alert} : 8'h00;
  assign d16 = {conv_data, app[3:0]};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_r  <= '0;
      sdo_r <= 1'b0;
    end else if (cs_fall) begin
      if (rd_pend_r) begin
        tx_r  <= crc_en ? {rd_data_r, crc8({rd_data_r, 16'h0000}, RD_BITS), 16'h0000}
                        : {rd_data_r, 24'h000000};
        sdo_r <= rd_data_r[7];
      end else begin
        tx_r  <= crc_en ? {d16, crc8({d16, 8'h00}, CONV_BITS), 8'h00}
                        : {d16, 16'h0000};
        sdo_r <= d16[15];
      end
    end else if (sck_fall) begin
      tx_r  <= {tx_r[30:0], 1'b0};
      sdo_r <= tx_r[30];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= flag_set && prot_r[PROT_ALERT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= flag_r && prot_r[PROT_STOP];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_eff_r  <= REG_RST;
      gpio_eff_r <= REG_RST;
    end else if (flag_r && prot_r[PROT_SAFE]) begin
      pin_eff_r  <= REG_RST;
      gpio_eff_r <= REG_RST;
    end else begin
      pin_eff_r  <= pin_r;
      gpio_eff_r <= gpio_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        A_STATUS: rdata_r <= {7'h00, flag_r};
        A_GEN:    rdata_r <= gen_r;
        A_PROT:   rdata_r <= prot_r;
        A_GPIO:   rdata_r <= gpio_r;
        A_PIN:    rdata_r <= pin_r;
        default:  rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign spi_sdo      = sdo_r;
  assign reg_rdata    = rdata_r;
  assign alert        = alert_r;
  assign conv_abort   = abort_r;
  assign pin_cfg_eff  = pin_eff_r;
  assign gpio_cfg_eff = gpio_eff_r;
  assign cmd_valid    = cmd_valid_r;
  assign cmd          = cmd_r;

  // Checks
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_flag_set;
    frame_done && crc_en && cnt_r != FRAME_BITS |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("short frame not flagged");
  property p_no_flag_off;
    $rose(flag_r) |-> $past(crc_en) && $past(frame_done);
  endproperty
  a_no_flag_off: assert property (p_no_flag_off) else $error("flag set without cause");
  property p_drop;
    frame_done && frame_err |=> !cmd_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("bad frame executed");
  property p_alert;
    flag_set && prot_r[PROT_ALERT] |=> alert ##1 !alert;
  endproperty
  a_alert: assert property (p_alert) else $error("alert pulse wrong");
  property p_block;
    flag_r && !flag_clr && reg_we && reg_addr == A_PIN && !spi_wr |=> $stable(pin_r);
  endproperty
  a_block: assert property (p_block) else $error("write passed while flagged");
  property p_gen_ok;
    reg_we && reg_addr == A_GEN && !spi_wr |=> gen_r == $past(reg_wdata);
  endproperty
  a_gen_ok: assert property (p_gen_ok) else $error("config write lost");
  property p_safe;
    flag_r && prot_r[PROT_SAFE] |=> pin_cfg_eff == REG_RST;
  endproperty
  a_safe: assert property (p_safe) else $error("channel not safe");
  property p_abort;
    flag_r && prot_r[PROT_STOP] ##1 flag_r |-> conv_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("conversions not aborted");
  property p_restore;
    $fell(flag_r) ##1 $stable(pin_r) |-> pin_cfg_eff == pin_r;
  endproperty
  a_restore: assert property (p_restore) else $error("channels not restored");
  c_err:   cover property (@(posedge clk) disable iff (reset) flag_set);
  c_rd:    cover property (@(posedge clk) disable iff (reset) frame_ok && pl.opcode == OP_RD);
  c_wr:    cover property (@(posedge clk) disable iff (reset) spi_wr && crc_en);
  c_clear: cover property (@(posedge clk) disable iff (reset) $fell(flag_r));
endmodule

// ### bench/sfc_host_model.sv
// Host model driving serial command frames
`timescale 1ns/1ps

module sfc_host_model
  import sfc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end

  task automatic frame(input logic [39:0] w, input int n, output logic [39:0] rx);
    rx = '0;
    spi_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_sdi <= w[i];
      repeat (4) @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rx = {rx[38:0], spi_sdo};
      @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    // Released line shows inverse level
    spi_sdi  <= ~w[0];
    repeat (12) @(posedge clk);
  endtask
endmodule

// ### bench/sfc_checker_tb.sv
// Self-checking bench for the serial frame checksum checker
`timescale 1ns/1ps

module sfc_checker_tb;
  import sfc_pkg::*;

  logic        clk;
  logic        reset;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata;
  logic [11:0] conv_data;
  logic        event_alert;
  logic        alert;
  logic        conv_abort;
  logic [7:0]  pin_eff;
  logic [7:0]  gpio_eff;
  logic        cmd_valid;
  sfc_cmd_t    cmd;
  logic [39:0] rx;
  logic [7:0]  pv;
  logic [7:0]  gv;
  logic [15:0] d16;
  logic [7:0]  rq[$];
  sfc_cmd_t    cq[$];
  logic        re_d;
  int          failures;
  int          samples_checked;
  int          n_alert;
  int          na;
  int          lens[3] = '{32, 31, 33};

  sfc_checker u_dut (
    .clk         (clk),
    .reset       (reset),
    .spi_cs_n    (cs_n),
    .spi_sclk    (sclk),
    .spi_sdi     (sdi),
    .spi_sdo     (sdo),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_we      (reg_we),
    .reg_re      (reg_re),
    .reg_rdata   (reg_rdata),
    .conv_data   (conv_data),
    .event_alert (event_alert),
    .alert       (alert),
    .conv_abort  (conv_abort),
    .pin_cfg_eff (pin_eff),
    .gpio_cfg_eff(gpio_eff),
    .cmd_valid   (cmd_valid),
    .cmd         (cmd)
  );

  sfc_host_model u_host (
    .clk     (clk),
    .spi_cs_n(cs_n),
    .spi_sclk(sclk),
    .spi_sdi (sdi),
    .spi_sdo (sdo)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [23:0] d, input int n);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_re <= 1'b0;
  endtask

  task automatic sfr(input sfc_cmd_t c, input logic [7:0] flip, input int n, input bit ok);
    logic [39:0] w;
    w = {8'h00, c, crc8(c, 24) ^ flip};
    w = (n <= 32) ? w >> (32 - n) : w << (n - 32);
    if (ok) cq.push_back(c);
    u_host.frame(w, n, rx);
  endtask

  // Watches outputs against noted expectations
  always @(posedge clk) begin
    re_d <= reg_re;
    if (re_d === 1'b1) chk("reg_rdata", reg_rdata, rq.pop_front());
    if (alert === 1'b1) n_alert++;
    if (cmd_valid === 1'b1) begin
      if (cq.size() == 0) chk("cmd_dropped", cmd, '0);
      else chk("cmd", cmd, cq.pop_front());
    end
  end

  initial begin
    #1000000;
    failures++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    conv_data = 12'h000;
    event_alert = 1'b0;
    void'($urandom(32'hF8652B24));
    pv = 8'($urandom) | 8'h01;
    gv = 8'($urandom);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (lens[i]) rd(8'(A_STATUS + i), REG_RST);
    rd(8'h7F, 8'h00);
    rd(A_PIN, REG_RST);
    wr(A_GEN, 8'h40);
    sfr('{OP_WR, A_PROT, 8'h27}, 8'h00, 32, 1);
    rd(A_PROT, 8'h27);
    wr(A_PIN, pv);
    wr(A_GPIO, gv);
    repeat (2) @(posedge clk);
    chk("pin_eff", pin_eff, pv);
    chk("gpio_eff", gpio_eff, gv);
    foreach (lens[i]) begin
      na = n_alert;
      sfr('{OP_WR, A_PIN, 8'h00}, (i == 0) ? 8'h01 : 8'h00, lens[i], 0);
      chk("alert_count", n_alert, na + 1);
      rd(A_STATUS, 8'h01);
      chk("pin_safe", pin_eff, 8'h00);
      chk("gpio_safe", gpio_eff, 8'h00);
      chk("conv_abort", conv_abort, 1'b1);
      wr(A_STATUS, 8'h01);
    end
    sfr('{OP_WR, A_GPIO, 8'h00}, 8'h80, 32, 0);
    wr(A_PIN, 8'h0F);
    sfr('{OP_WR, A_PIN, 8'h0F}, 8'h00, 32, 1);
    rd(A_PIN, pv);
    sfr('{OP_RD, A_PIN, 8'h00}, 8'h00, 32, 1);
    sfr('{OP_RD, A_GEN, 8'h00}, 8'h00, 32, 1);
    chk("sdo_read", rx, {pv, crc8(pv, 8), 16'h0000});
    conv_data <= 12'($urandom);
    event_alert <= 1'($urandom);
    sfr('{OP_WR, A_GEN, 8'h40}, 8'h00, 32, 1);
    chk("sdo_gen", rx, {8'h40, crc8(8'h40, 8), 16'h0000});
    d16 = {conv_data, STAT_HI, 1'b1, event_alert};
    sfr('{OP_WR, A_STATUS, 8'h01}, 8'h00, 32, 1);
    chk("sdo_conv", rx, {d16, crc8(d16, 16), 8'h00});
    rd(A_STATUS, 8'h00);
    chk("pin_restore", pin_eff, pv);
    chk("gpio_restore", gpio_eff, gv);
    chk("conv_run", conv_abort, 1'b0);
    wr(A_GEN, 8'h00);
    sfr('{OP_WR, A_PIN, 8'h3C}, 8'h00, 24, 1);
    d16 = {conv_data, STAT_HI, 1'b0, event_alert};
    chk("sdo_plain", rx, {d16, 8'h00});
    rd(A_PIN, 8'h3C);
    rd(A_STATUS, 8'h00);
    repeat (4) @(posedge clk);
    chk("cmd_left", cq.size(), 0);
    finish_test();
  end
endmodule
